// ---- logic/ssnd_detect.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ssnd_defs.svh"

module ssnd_detect (
   input  wire logic               sys_clk,
   input  wire logic               rst_b,
   // avalon-mm slave
   input  wire ssnd_pkg::ssnd_addr_t avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire ssnd_pkg::ssnd_word_t avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output var  ssnd_pkg::ssnd_word_t avs_readdata,
   output logic                    avs_waitrequest,
   // pulse datapaths 1..3 (bit 0 is path 1)
   input  wire logic [2:0]         stage1_done,
   input  wire logic [2:0]         stage1_sum_neg,
   input  wire logic [2:0]         pulse_output_pin,
   // per-phase power signs (bit 0 is phase a)
   input  wire logic [2:0]         phase_active_neg,
   input  wire logic [2:0]         phase_reactive_neg,
   // per-phase energy lsb events and no-load time base
   input  wire logic [2:0]         active_lsb,
   input  wire logic [2:0]         reactive_lsb,
   input  wire logic [2:0]         fund_active_lsb,
   input  wire logic [2:0]         fund_reactive_lsb,
   input  wire logic               noload_tick,
   // to the accumulators
   output var  ssnd_pkg::ssnd_phase_t reactive_add_neg,
   output var  ssnd_pkg::ssnd_phase_t total_accum_hold,
   output var  ssnd_pkg::ssnd_phase_t fund_accum_hold,
   // interrupt pins, active low
   output var  logic               interrupt_pin_zero_b,
   output var  logic               interrupt_pin_one_b
);
   import ssnd_pkg::*;

   // byte-lane merge of a write into a stored word
   function automatic ssnd_word_t be_merge(input ssnd_word_t old_v,
                                           input ssnd_word_t new_v,
                                           input logic [3:0] be);
      ssnd_word_t res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : be_merge
   // sticky flag: a set in the clearing cycle wins
   function automatic logic flag_upd(input logic cur,
                                     input logic set,
                                     input logic clr);
      return set | (cur & ~clr);
   endfunction : flag_upd

   // no-load state step for one phase
   function automatic logic nl_step(input logic cur,
                                    input logic ena,
                                    input logic lsb_any,
                                    input logic both_expired);
      logic res;
      res = 1'b0;
      if (ena) begin
         if (cur) begin
            res = ~lsb_any;
         end else begin
            res = both_expired & ~lsb_any;
         end
      end
      return res;
   endfunction : nl_step

   // bus handshake
   logic       ack_ff;
   logic       req;
   logic       wr_go;
   logic [15:0] idx;
   ssnd_word_t be_mask;
   // registers
   ssnd_word_t     en0_ff;
   ssnd_word_t     en1_ff;
   ssnd_thr_t      ap_thr_ff;
   ssnd_thr_t      var_thr_ff;
   ssnd_var_mode_t var_mode_ff;
   logic [2:0]     sumchg_ff;        // line 0 flags, path 1..3
   logic [2:0]     sum_sign_ff;      // sign bits, path 1..3
   logic           tot_nl_flag_ff;
   logic           fund_nl_flag_ff;
   ssnd_word_t     readdata_ff;
   // sign tracking
   logic [2:0] last_sign_ff;
   logic [2:0] pend_ff;
   logic [2:0] pend_sign_ff;
   logic [2:0] pin_prev_ff;
   logic [2:0] pin_fall;
   logic [2:0] sumchg_set;
   // no-load detection
   ssnd_thr_t  tot_act_cnt_ff  [3];
   ssnd_thr_t  tot_var_cnt_ff  [3];
   ssnd_thr_t  fund_act_cnt_ff [3];
   ssnd_thr_t  fund_var_cnt_ff [3];
   logic [2:0] tot_nl_ff;
   logic [2:0] fund_nl_ff;
   logic [2:0] nxt_tot_nl;
   logic [2:0] nxt_fund_nl;
   logic       nl_ena;
   // clear strobes from status writes
   ssnd_word_t st0_word;
   ssnd_word_t st1_word;
   ssnd_word_t sign_word;
   ssnd_word_t phnl_word;
   logic       clr_st0;
   logic       clr_st1;
   ssnd_word_t w1c;
   // request decode; one wait cycle then the answer
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_ff;
   assign wr_go           = avs_write & ack_ff;
   assign idx             = avs_address[17:2];
   assign avs_readdata    = readdata_ff;
   assign clr_st0         = wr_go & (idx == `SSND_IDX_ST0);
   assign clr_st1         = wr_go & (idx == `SSND_IDX_ST1);

   // byte enables expanded to a bit mask for write-one-to-clear
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         be_mask[i*8 +: 8] = {8{avs_byteenable[i]}};
      end
      w1c = avs_writedata & be_mask;
   end

   // acknowledge flop
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   // assembled read words
   always_comb begin
      st0_word                     = `SSND_RST_WORD;
      st0_word[`SSND_BIT_SUMCHG1]  = sumchg_ff[0];
      st0_word[`SSND_BIT_SUMCHG2]  = sumchg_ff[1];
      st0_word[`SSND_BIT_SUMCHG3]  = sumchg_ff[2];
      st1_word                     = `SSND_RST_WORD;
      st1_word[`SSND_BIT_TOT_NL]   = tot_nl_flag_ff;
      st1_word[`SSND_BIT_FUND_NL]  = fund_nl_flag_ff;
      sign_word                    = `SSND_RST_WORD;
      sign_word[`SSND_BIT_SUM1SIGN] = sum_sign_ff[0];
      sign_word[`SSND_BIT_SUM2SIGN] = sum_sign_ff[1];
      sign_word[`SSND_BIT_SUM3SIGN] = sum_sign_ff[2];
      phnl_word                    = `SSND_RST_WORD;
      phnl_word[`SSND_LSB_TOT_PHASE +: 3]  = tot_nl_ff;
      phnl_word[`SSND_LSB_FUND_PHASE +: 3] = fund_nl_ff;
   end

   // read data captured on the first request cycle; unmapped reads zero
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         readdata_ff <= `SSND_RST_WORD;
      end else if (avs_read & ~ack_ff) begin
         unique case (idx)
            `SSND_IDX_ST0:        readdata_ff <= st0_word;
            `SSND_IDX_ST1:        readdata_ff <= st1_word;
            `SSND_IDX_EN0:        readdata_ff <= en0_ff;
            `SSND_IDX_EN1:        readdata_ff <= en1_ff;
            `SSND_IDX_NL_STATE:   readdata_ff <= phnl_word;
            `SSND_IDX_SIGN:       readdata_ff <= sign_word;
            `SSND_IDX_ACCMODE:    readdata_ff <= {28'h000_0000, var_mode_ff, 2'h0};
            `SSND_IDX_AP_NOLOAD:  readdata_ff <= {16'h0000, ap_thr_ff};
            `SSND_IDX_VAR_NOLOAD: readdata_ff <= {16'h0000, var_thr_ff};
            default:              readdata_ff <= `SSND_RST_WORD;
         endcase
      end
   end

   // enable registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         en0_ff <= `SSND_RST_WORD;
         en1_ff <= `SSND_RST_WORD;
      end else if (wr_go) begin
         if (idx == `SSND_IDX_EN0) begin
            en0_ff <= be_merge(en0_ff, avs_writedata, avs_byteenable);
         end
         if (idx == `SSND_IDX_EN1) begin
            en1_ff <= be_merge(en1_ff, avs_writedata, avs_byteenable);
         end
      end
   end

   // no-load thresholds and reactive accumulation mode
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ap_thr_ff   <= `SSND_RST_THR;
         var_thr_ff  <= `SSND_RST_THR;
         var_mode_ff <= SSND_VAR_SIGNED;
      end else if (wr_go) begin
         if (idx == `SSND_IDX_AP_NOLOAD) begin
            ap_thr_ff <= ssnd_thr_t'(be_merge({16'h0000, ap_thr_ff}, avs_writedata,
                                              avs_byteenable));
         end
         if (idx == `SSND_IDX_VAR_NOLOAD) begin
            var_thr_ff <= ssnd_thr_t'(be_merge({16'h0000, var_thr_ff}, avs_writedata,
                                               avs_byteenable));
         end
         if ((idx == `SSND_IDX_ACCMODE) && avs_byteenable[0]) begin
            var_mode_ff <= ssnd_var_mode_t'(avs_writedata[`SSND_LSB_VAR_MODE +: 2]);
         end
      end
   end

   // sign applied when a phase reactive power enters the var-hour sum
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reactive_add_neg <= 3'h0;
      end else begin
         unique case (var_mode_ff)
            SSND_VAR_ABSOLUTE:  reactive_add_neg <= phase_reactive_neg;
            SSND_VAR_BY_ACTIVE: reactive_add_neg <= phase_active_neg;
            SSND_VAR_SIGNED,
            SSND_VAR_RESERVED:  reactive_add_neg <= 3'h0;
         endcase
      end
   end

   // falling edges on the pulse outputs
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_prev_ff <= 3'h7;                                      // idle high
      end else begin
         pin_prev_ff <= pulse_output_pin;
      end
   end

   assign pin_fall   = pin_prev_ff & ~pulse_output_pin;
   assign sumchg_set = pin_fall & pend_ff;
   // sign sampled at each first-stage crossing, change held pending
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         last_sign_ff <= 3'h0;
         pend_ff      <= 3'h0;
         pend_sign_ff <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (sumchg_set[i]) begin
               pend_ff[i] <= 1'b0;
            end
            if (stage1_done[i]) begin
               last_sign_ff[i] <= stage1_sum_neg[i];
               if (stage1_sum_neg[i] != last_sign_ff[i]) begin
                  pend_ff[i]      <= 1'b1;
                  pend_sign_ff[i] <= stage1_sum_neg[i];
               end
            end
         end
      end
   end

   // sign change flags and sign bits, set at the pulse edge
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sumchg_ff   <= 3'h0;
         sum_sign_ff <= 3'h0;
      end else begin
         sumchg_ff[0] <= flag_upd(sumchg_ff[0], sumchg_set[0],
                                  clr_st0 & w1c[`SSND_BIT_SUMCHG1]);
         sumchg_ff[1] <= flag_upd(sumchg_ff[1], sumchg_set[1],
                                  clr_st0 & w1c[`SSND_BIT_SUMCHG2]);
         sumchg_ff[2] <= flag_upd(sumchg_ff[2], sumchg_set[2],
                                  clr_st0 & w1c[`SSND_BIT_SUMCHG3]);
         for (int i = 0; i < 3; i++) begin
            if (sumchg_set[i]) begin
               sum_sign_ff[i] <= pend_sign_ff[i];
            end
         end
      end
   end

   // either threshold at zero disables both detectors
   assign nl_ena = (ap_thr_ff != `SSND_RST_THR) && (var_thr_ff != `SSND_RST_THR);
   // quiet-time counters restart from the threshold on every lsb
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tot_act_cnt_ff  <= '{default: `SSND_RST_CNT};
         tot_var_cnt_ff  <= '{default: `SSND_RST_CNT};
         fund_act_cnt_ff <= '{default: `SSND_RST_CNT};
         fund_var_cnt_ff <= '{default: `SSND_RST_CNT};
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (!nl_ena || active_lsb[i]) begin
               tot_act_cnt_ff[i] <= ap_thr_ff;
            end else if (noload_tick && tot_act_cnt_ff[i] != `SSND_CNT_END) begin
               tot_act_cnt_ff[i] <= tot_act_cnt_ff[i] + 16'h0001;
            end
            if (!nl_ena || reactive_lsb[i]) begin
               tot_var_cnt_ff[i] <= var_thr_ff;
            end else if (noload_tick && tot_var_cnt_ff[i] != `SSND_CNT_END) begin
               tot_var_cnt_ff[i] <= tot_var_cnt_ff[i] + 16'h0001;
            end
            if (!nl_ena || fund_active_lsb[i]) begin
               fund_act_cnt_ff[i] <= ap_thr_ff;
            end else if (noload_tick && fund_act_cnt_ff[i] != `SSND_CNT_END) begin
               fund_act_cnt_ff[i] <= fund_act_cnt_ff[i] + 16'h0001;
            end
            if (!nl_ena || fund_reactive_lsb[i]) begin
               fund_var_cnt_ff[i] <= var_thr_ff;
            end else if (noload_tick && fund_var_cnt_ff[i] != `SSND_CNT_END) begin
               fund_var_cnt_ff[i] <= fund_var_cnt_ff[i] + 16'h0001;
            end
         end
      end
   end

   // next no-load state per phase
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         nxt_tot_nl[i]  = nl_step(tot_nl_ff[i], nl_ena,
                                  active_lsb[i] | reactive_lsb[i],
                                  (tot_act_cnt_ff[i] == `SSND_CNT_END) &&
                                  (tot_var_cnt_ff[i] == `SSND_CNT_END));
         nxt_fund_nl[i] = nl_step(fund_nl_ff[i], nl_ena,
                                  fund_active_lsb[i] | fund_reactive_lsb[i],
                                  (fund_act_cnt_ff[i] == `SSND_CNT_END) &&
                                  (fund_var_cnt_ff[i] == `SSND_CNT_END));
      end
   end

   // per-phase no-load state, shown as indicators and accumulator holds
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tot_nl_ff  <= 3'h0;
         fund_nl_ff <= 3'h0;
      end else begin
         tot_nl_ff  <= nxt_tot_nl;
         fund_nl_ff <= nxt_fund_nl;
      end
   end

   assign total_accum_hold = tot_nl_ff;
   assign fund_accum_hold  = fund_nl_ff;
   // no-load flags set on entry or exit of any phase, whatever the enables
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tot_nl_flag_ff  <= 1'b0;
         fund_nl_flag_ff <= 1'b0;
      end else begin
         tot_nl_flag_ff  <= flag_upd(tot_nl_flag_ff, |(nxt_tot_nl ^ tot_nl_ff),
                                     clr_st1 & w1c[`SSND_BIT_TOT_NL]);
         fund_nl_flag_ff <= flag_upd(fund_nl_flag_ff, |(nxt_fund_nl ^ fund_nl_ff),
                                     clr_st1 & w1c[`SSND_BIT_FUND_NL]);
      end
   end

   // interrupt pins low while any enabled flag stands
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         interrupt_pin_zero_b <= 1'b1;
         interrupt_pin_one_b  <= 1'b1;
      end else begin
         interrupt_pin_zero_b <= ~|(st0_word & en0_ff);
         interrupt_pin_one_b  <= ~|(st1_word & en1_ff);
      end
   end

endmodule : ssnd_detect
`default_nettype wire

// ---- logic/ssnd_defs.svh ----
`ifndef SSND_DEFS_SVH
`define SSND_DEFS_SVH

// register indexes; byte address on the bus is four times the index
`define SSND_IDX_ST0          16'he502
`define SSND_IDX_ST1          16'he503
`define SSND_IDX_EN0          16'he50a
`define SSND_IDX_EN1          16'he50b
`define SSND_IDX_NL_STATE     16'he608
`define SSND_IDX_SIGN         16'he617
`define SSND_IDX_ACCMODE      16'he701
`define SSND_IDX_AP_NOLOAD    16'he908
`define SSND_IDX_VAR_NOLOAD   16'he909

// field positions in the line 0 status and enable registers
`define SSND_BIT_SUMCHG1      9
`define SSND_BIT_SUMCHG2      13
`define SSND_BIT_SUMCHG3      18

// field positions in the line 1 status and enable registers
`define SSND_BIT_TOT_NL       0
`define SSND_BIT_FUND_NL      1

// field positions in the sign register
`define SSND_BIT_SUM1SIGN     3
`define SSND_BIT_SUM2SIGN     7
`define SSND_BIT_SUM3SIGN     8

// field positions in the phase no-load register
`define SSND_LSB_TOT_PHASE    0
`define SSND_LSB_FUND_PHASE   3

// field position of the reactive accumulation mode
`define SSND_LSB_VAR_MODE     2

// reset values and the counter end value
`define SSND_RST_WORD         32'h0000_0000
`define SSND_RST_THR          16'h0000
`define SSND_RST_CNT          16'h0000
`define SSND_CNT_END          16'hffff

`endif

// ---- logic/ssnd_pkg.sv ----
package ssnd_pkg;

   // reactive accumulation mode field
   typedef enum logic [1:0] {
      SSND_VAR_SIGNED,
      SSND_VAR_RESERVED,
      SSND_VAR_BY_ACTIVE,
      SSND_VAR_ABSOLUTE
   } ssnd_var_mode_t;

   typedef logic [2:0]  ssnd_phase_t;
   typedef logic [15:0] ssnd_thr_t;
   typedef logic [31:0] ssnd_word_t;
   typedef logic [17:0] ssnd_addr_t;

endpackage : ssnd_pkg

// ---- dv/ssnd_detect_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssnd_detect_asserts (
   input wire logic                  sys_clk,
   input wire logic                  rst_b,
   input wire logic                  avs_read,
   input wire logic                  avs_write,
   input wire ssnd_pkg::ssnd_word_t  avs_readdata,
   input wire logic                  avs_waitrequest,
   input wire logic [2:0]            pulse_output_pin,
   input wire logic [2:0]            phase_active_neg,
   input wire logic [2:0]            phase_reactive_neg,
   input wire logic [2:0]            active_lsb,
   input wire logic [2:0]            reactive_lsb,
   input wire logic [2:0]            fund_active_lsb,
   input wire logic [2:0]            fund_reactive_lsb,
   input wire ssnd_pkg::ssnd_phase_t reactive_add_neg,
   input wire ssnd_pkg::ssnd_phase_t total_accum_hold,
   input wire ssnd_pkg::ssnd_phase_t fund_accum_hold,
   input wire logic                  interrupt_pin_zero_b,
   input wire logic                  interrupt_pin_one_b
);
   import ssnd_pkg::*;
   // single clock domain; reset silences every check
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   // accepted write, takes effect at this edge
   logic wr_ok;
   assign wr_ok = avs_write && !avs_waitrequest;
   // bus handshake: a fresh request waits exactly one cycle
   wait_first_a: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
      |-> avs_waitrequest) else $error("new request not held off");
   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("request waited too long");
   rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
      else $error("read data moved without a read");
   // negated reactive add only for phases with a negative power sign
   add_neg_src_a: assert property ((reactive_add_neg
      & ~$past(phase_active_neg | phase_reactive_neg)) == 3'h0) else $error("bad negate");
   // interrupt pins fall two edges after a cause: flag edge, then pin edge
   interrupt_pin_zero_cause_a: assert property ($fell(interrupt_pin_zero_b) |-> $past(wr_ok, 2)
      || ($past(~pulse_output_pin, 2) & $past(pulse_output_pin, 3)) != 3'h0)
      else $error("pin zero fell without pulse edge");
   interrupt_pin_one_cause_a: assert property ($fell(interrupt_pin_one_b) |-> $past(wr_ok, 2)
      || $past(total_accum_hold) != $past(total_accum_hold, 2)
      || $past(fund_accum_hold) != $past(fund_accum_hold, 2))
      else $error("pin one fell without no-load change");
   irq_release_a: assert property ($rose(interrupt_pin_zero_b) || $rose(interrupt_pin_one_b)
      |-> $past(wr_ok, 2)) else $error("pin released without clear");
   // no-load entry needs a quiet cycle, exit follows any lsb
   nl_enter_quiet_a: assert property ((total_accum_hold & ~$past(total_accum_hold)
      & $past(active_lsb | reactive_lsb)) == 3'h0) else $error("entered with lsb");
   nl_exit_lsb_a: assert property ((total_accum_hold
      & $past(total_accum_hold & (active_lsb | reactive_lsb))) == 3'h0)
      else $error("total no-load kept after lsb");
   fnl_exit_lsb_a: assert property ((fund_accum_hold
      & $past(fund_accum_hold & (fund_active_lsb | fund_reactive_lsb))) == 3'h0)
      else $error("fund no-load kept after lsb");
   // main scenarios reached
   cover property ($fell(interrupt_pin_zero_b));
   cover property ($rose(total_accum_hold[0]));
   cover property ($rose(fund_accum_hold[0]));
endmodule : ssnd_detect_asserts
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ssnd_defs.svh"
module testbench;
   import ssnd_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst_b = 1'b0;
   ssnd_addr_t  avs_address = 18'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   ssnd_word_t  avs_writedata = 32'h0;
   logic [2:0]  stage1_done = 3'h0, stage1_sum_neg = 3'h0, pulse_output_pin = 3'h7;
   logic [2:0]  phase_active_neg = 3'h0, phase_reactive_neg = 3'h0;
   logic [2:0]  active_lsb = 3'h0, reactive_lsb = 3'h0;
   logic [2:0]  fund_active_lsb = 3'h0, fund_reactive_lsb = 3'h0;
   logic        noload_tick = 1'b0;
   ssnd_word_t  avs_readdata;
   logic        avs_waitrequest;
   ssnd_phase_t reactive_add_neg, total_accum_hold, fund_accum_hold;
   logic        interrupt_pin_zero_b, interrupt_pin_one_b;
   int          mismatches = 0;
   int          num_checks = 0;
   logic [31:0] seed = 32'h19c4489e;
   logic [15:0] tab [0:9] = '{`SSND_IDX_ST0, `SSND_IDX_ST1, `SSND_IDX_EN0,
      `SSND_IDX_EN1, `SSND_IDX_NL_STATE, `SSND_IDX_SIGN, `SSND_IDX_ACCMODE,
      `SSND_IDX_AP_NOLOAD, `SSND_IDX_VAR_NOLOAD, 16'h0100};

   ssnd_detect dut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .stage1_done(stage1_done), .stage1_sum_neg(stage1_sum_neg),
      .pulse_output_pin(pulse_output_pin), .phase_active_neg(phase_active_neg),
      .phase_reactive_neg(phase_reactive_neg), .active_lsb(active_lsb),
      .reactive_lsb(reactive_lsb), .fund_active_lsb(fund_active_lsb),
      .fund_reactive_lsb(fund_reactive_lsb), .noload_tick(noload_tick),
      .reactive_add_neg(reactive_add_neg), .total_accum_hold(total_accum_hold),
      .fund_accum_hold(fund_accum_hold), .interrupt_pin_zero_b(interrupt_pin_zero_b),
      .interrupt_pin_one_b(interrupt_pin_one_b));

   // 250 MHz clock
   always #2 sys_clk = ~sys_clk;

   // xorshift source with fixed seed
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // expected sign-change status and sign register words
   function automatic ssnd_word_t sb0(input logic [2:0] f);
      return (32'(f[0]) << `SSND_BIT_SUMCHG1) | (32'(f[1]) << `SSND_BIT_SUMCHG2)
         | (32'(f[2]) << `SSND_BIT_SUMCHG3);
   endfunction : sb0
   function automatic ssnd_word_t sgn(input logic [2:0] f);
      return (32'(f[0]) << `SSND_BIT_SUM1SIGN) | (32'(f[1]) << `SSND_BIT_SUM2SIGN)
         | (32'(f[2]) << `SSND_BIT_SUM3SIGN);
   endfunction : sgn

   task automatic chk(input string n, input ssnd_word_t seen, input ssnd_word_t exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   // one avalon transfer; holds the request until waitrequest is low at an edge
   task automatic bus(input logic w, input logic [15:0] ix, input ssnd_word_t wd,
                      output ssnd_word_t rd);
      @(posedge sys_clk);
      avs_address <= {ix, 2'b00};
      avs_writedata <= wd;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic wr(input logic [15:0] ix, input ssnd_word_t d);
      ssnd_word_t x;
      bus(1'b1, ix, d, x);
   endtask : wr

   task automatic rdc(input logic [15:0] ix, input ssnd_word_t e, input string n);
      ssnd_word_t x;
      bus(1'b0, ix, 32'h0, x);
      chk(n, x, e);
   endtask : rdc

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc

   // time-base ticks, with lsb events on the phases in l
   task automatic ticks(input int n, input logic [2:0] l);
      repeat (n) begin
         noload_tick <= 1'b1;
         {active_lsb, reactive_lsb, fund_active_lsb, fund_reactive_lsb} <= {4{l}};
         @(posedge sys_clk);
         noload_tick <= 1'b0;
         {active_lsb, reactive_lsb, fund_active_lsb, fund_reactive_lsb} <= 12'h0;
         @(posedge sys_clk);
      end
   endtask : ticks

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   // watchdog
   initial begin
      cyc(40000);
      mismatches++;
      wrap_up();
   end

   initial begin
      int p;
      logic [31:0] r;
      logic [2:0] ef, es, em, c, q;
      ef = 3'h0;
      es = 3'h0;
      em = 3'h0;
      cyc(6);
      rst_b <= 1'b1;
      // reset values, read-only and unmapped writes refused
      wr(`SSND_IDX_SIGN, 32'hffffffff);
      wr(16'h0100, 32'hffffffff);
      foreach (tab[k]) rdc(tab[k], 32'h0, "reset value");
      chk("irq pins", 32'({interrupt_pin_zero_b, interrupt_pin_one_b}), 32'h3);
      wr(`SSND_IDX_EN0, 32'hffffffff);
      rdc(`SSND_IDX_EN0, 32'hffffffff, "en0 rw");
      wr(`SSND_IDX_EN0, 32'h0);
      $display("test regs done");
      // reactive accumulation modes
      for (int m = 0; m < 4; m++) begin
         r = rnd();
         phase_active_neg <= r[2:0];
         phase_reactive_neg <= r[5:3];
         wr(`SSND_IDX_ACCMODE, 32'(m) << `SSND_LSB_VAR_MODE);
         cyc(2);
         chk("add neg", 32'(reactive_add_neg),
             m == 3 ? 32'(r[5:3]) : m == 2 ? 32'(r[2:0]) : 32'h0);
      end
      $display("test mode done");
      // sum sign changes, flagged on the next pulse falling edge
      for (int i = 0; i < 12; i++) begin
         r = rnd();
         p = int'(r[15:0]) % 3;
         @(posedge sys_clk);
         stage1_done <= 3'h1 << p;
         stage1_sum_neg <= {3{r[4]}};
         @(posedge sys_clk);
         stage1_done <= 3'h0;
         rdc(`SSND_IDX_ST0, sb0(ef), "st0 early");
         pulse_output_pin <= ~(3'h1 << p);
         cyc(2);
         pulse_output_pin <= 3'h7;
         if (r[4] !== es[p]) begin
            ef[p] = 1'b1;
            es[p] = r[4];
         end
         cyc(2);
         rdc(`SSND_IDX_ST0, sb0(ef), "st0");
         rdc(`SSND_IDX_SIGN, sgn(es), "sign");
         chk("interrupt_pin_zero", 32'(interrupt_pin_zero_b), 32'(~|(ef & em)));
         em = r[7:5];
         c = r[10:8];
         wr(`SSND_IDX_EN0, sb0(em));
         wr(`SSND_IDX_ST0, sb0(c));
         ef = ef & ~c;
         cyc(2);
         chk("interrupt_pin_zero clear", 32'(interrupt_pin_zero_b), 32'(~|(ef & em)));
      end
      $display("test sign done");
      // no-load: 65535 - 0xfff0 = 15 ticks
      wr(`SSND_IDX_AP_NOLOAD, 32'h0000fff0);
      wr(`SSND_IDX_VAR_NOLOAD, 32'h0000fff0);
      wr(`SSND_IDX_EN1, 32'h3);
      r = rnd();
      q = r[2:0] | 3'h1;
      ticks(1, 3'h7);
      ticks(14, ~q);
      chk("hold early", 32'({total_accum_hold, fund_accum_hold}), 32'h0);
      ticks(1, ~q);
      cyc(2);
      chk("total hold", 32'(total_accum_hold), 32'(q));
      chk("fund hold", 32'(fund_accum_hold), 32'(q));
      rdc(`SSND_IDX_ST1, 32'h3, "st1 set");
      rdc(`SSND_IDX_NL_STATE, 32'({q, q}), "nl state");
      chk("interrupt_pin_one low", 32'(interrupt_pin_one_b), 32'h0);
      wr(`SSND_IDX_ST1, 32'h3);
      cyc(2);
      chk("interrupt_pin_one high", 32'(interrupt_pin_one_b), 32'h1);
      rdc(`SSND_IDX_ST1, 32'h0, "st1 clr");
      @(posedge sys_clk);
      active_lsb <= q;
      @(posedge sys_clk);
      active_lsb <= 3'h0;
      cyc(2);
      chk("total exit", 32'({total_accum_hold, fund_accum_hold}), 32'(q));
      rdc(`SSND_IDX_ST1, 32'h1, "st1 exit");
      rdc(`SSND_IDX_NL_STATE, 32'({q, 3'h0}), "nl state exit");
      wr(`SSND_IDX_AP_NOLOAD, 32'h0);
      ticks(20, 3'h0);
      chk("disabled", 32'({total_accum_hold, fund_accum_hold}), 32'h0);
      rdc(`SSND_IDX_ST1, 32'h3, "st1 off");
      $display("test noload done");
      wrap_up();
   end
endmodule : testbench

bind ssnd_detect ssnd_detect_asserts u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .pulse_output_pin(pulse_output_pin),
   .phase_active_neg(phase_active_neg), .phase_reactive_neg(phase_reactive_neg),
   .active_lsb(active_lsb), .reactive_lsb(reactive_lsb), .fund_active_lsb(fund_active_lsb),
   .fund_reactive_lsb(fund_reactive_lsb), .reactive_add_neg(reactive_add_neg),
   .total_accum_hold(total_accum_hold), .fund_accum_hold(fund_accum_hold),
   .interrupt_pin_zero_b(interrupt_pin_zero_b), .interrupt_pin_one_b(interrupt_pin_one_b));
`default_nettype wire
